// ===== ptp_defs.svh
// Constants for the pulse train and PWM output block
`ifndef PTP_DEFS_SVH
`define PTP_DEFS_SVH
`define PTP_CLK_HZ     32'h0EE6B280
`define PTP_CLK_MHZ    32'h000000FA
`define PTP_MIN_PH_US  32'h00000064
`define PTP_MIN_PH_CYC (`PTP_MIN_PH_US * `PTP_CLK_MHZ)
`define PTP_F_MIN      17'h00032
`define PTP_F_MAX      17'h01388
`define PTP_D_MAX      16'h0064
`define PTP_D_FULL     7'h64
`define PTP_D_ZERO     7'h00
`define PTP_D_HALF     7'h32
`define PTP_RND_PCT    32'h00000032
`define PTP_FN_PWM     16'h0001
`define PTP_FN_CWCCW   16'h0003
`define PTP_FN_PLSDIR  16'h0007
`define PTP_A_FUNC     5'h00
`define PTP_A_CTRL     5'h04
`define PTP_A_FREQ     5'h08
`define PTP_A_DUTY     5'h0C
`define PTP_A_ERR      5'h10
`define PTP_A_IST      5'h14
`define PTP_A_IMASK    5'h18
`define PTP_B_PW       0
`define PTP_B_DUTY     1
`define PTP_B_FREQ     2
`define PTP_B_EN       0
`define PTP_DIV_LAST   6'h1F
`endif

// ===== ptp_div.sv
// Iterative unsigned divider, one quotient bit per clock
`include "ptp_defs.svh"
`default_nettype none
module ptp_div (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        start_i,
  input  wire logic [31:0] num_i,
  input  wire logic [15:0] den_i,
  output logic             done_o,
  output logic [31:0]      quo_o
);
  ptp_pkg::ptp_div_type st_r, st_nxt;
  logic [16:0] trial;

  // Restoring division; divisor is captured so later writes cannot upset it
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    trial = {st_r.rem[15:0], st_r.quo[31]};
    if (start_i) begin
      st_nxt.busy = 1'b1;
      st_nxt.cnt  = 6'h00;
      st_nxt.den  = den_i;
      st_nxt.rem  = 17'h00000;
      st_nxt.quo  = num_i;
    end else if (st_r.busy) begin
      if (trial >= {1'b0, st_r.den}) begin
        st_nxt.rem = trial - {1'b0, st_r.den};
        st_nxt.quo = {st_r.quo[30:0], 1'b1};
      end else begin
        st_nxt.rem = trial;
        st_nxt.quo = {st_r.quo[30:0], 1'b0};
      end
      st_nxt.cnt = st_r.cnt + 6'h01;
      if (st_r.cnt == `PTP_DIV_LAST) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done_o = st_r.done;
  assign quo_o  = st_r.quo;
endmodule // ptp_div
`default_nettype wire

// ===== ptp_gen.sv
// Waveform counter: one period, high for the first part of it
`default_nettype none
module ptp_gen (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  ptp_gen_if.gen    g
);
  ptp_pkg::ptp_gen_type st_r, st_nxt;

  // New period or high time takes hold at once; count wraps if it overshoots
  always_comb begin
    st_nxt = st_r;
    if (!g.run) begin
      st_nxt.cnt  = 24'h000000;
      st_nxt.wave = 1'b0;
    end else begin
      st_nxt.wave = (st_r.cnt < g.high);
      if (st_r.cnt >= g.period - 24'h000001) begin
        st_nxt.cnt = 24'h000000;
      end else begin
        st_nxt.cnt = st_r.cnt + 24'h000001;
      end
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign g.wave = st_r.wave;
endmodule // ptp_gen
`default_nettype wire

// ===== ptp_gen_if.sv
// Link from the control logic to the waveform counter
`default_nettype none
interface ptp_gen_if;
  logic [23:0] period;
  logic [23:0] high;
  logic        run;
  logic        wave;
  modport ctl (output period, output high, output run, input wave);
  modport gen (input period, input high, input run, output wave);
endinterface
`default_nettype wire

// ===== ptp_load_model.sv
// Behavioural load on the two outputs: counts pulses and times the high phase of point zero
`default_nettype none
module ptp_load_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        point_zero_i,
  input  wire logic        point_one_i,
  output logic [15:0]      zero_rises_o,
  output logic [15:0]      one_rises_o,
  output logic [15:0]      zero_falls_o,
  output logic [23:0]      zero_high_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        zero_last_r;
  logic        one_last_r;
  logic [23:0] run_r;
  // A stepper drive reacts to edges only, so edges are counted and high time measured
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      zero_last_r  <= 1'b0;
      one_last_r   <= 1'b0;
      run_r        <= 24'h000000;
      zero_rises_o <= 16'h0000;
      one_rises_o  <= 16'h0000;
      zero_falls_o <= 16'h0000;
      zero_high_o  <= 24'h000000;
    end else begin
      zero_last_r <= point_zero_i;
      one_last_r  <= point_one_i;
      run_r       <= point_zero_i ? run_r + 24'h000001 : 24'h000000;
      if (point_zero_i && !zero_last_r) zero_rises_o <= zero_rises_o + 16'h0001;
      if (point_one_i && !one_last_r) one_rises_o <= one_rises_o + 16'h0001;
      // Latched at the falling edge, so a pulse cut short still shows its true length
      if (!point_zero_i && zero_last_r) begin
        zero_falls_o <= zero_falls_o + 16'h0001;
        zero_high_o  <= run_r;
      end
    end
  end
endmodule // ptp_load_model
`default_nettype wire

// ===== ptp_pkg.sv
// Types shared by the pulse train and PWM output modules
`default_nettype none
package ptp_pkg;
  typedef enum logic [1:0] {PTP_IDLE, PTP_PER, PTP_HIGH} ptp_st_type;

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [5:0]  cnt;
    logic [15:0] den;
    logic [16:0] rem;
    logic [31:0] quo;
  } ptp_div_type;

  typedef struct packed {
    logic [23:0] cnt;
    logic        wave;
  } ptp_gen_type;

  typedef struct packed {
    logic        wt;
    logic [15:0] rdata;
    logic [15:0] func;
    logic        en;
    logic [15:0] freq;
    logic        have_f;
    logic [6:0]  duty;
    logic        ferr;
    logic        derr;
    logic        pwerr;
    logic [2:0]  ist;
    logic [2:0]  imask;
    logic        irq;
    logic        pend;
    ptp_st_type  st;
    logic        sp;
    logic        sh;
    logic [23:0] per;
    logic [23:0] high;
    logic        run;
    logic        p0;
    logic        p1;
  } ptp_top_type;
endpackage
`default_nettype wire

// ===== ptp_top.sv
// Pulse train and PWM output generator with Avalon-MM register access
//
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`include "ptp_defs.svh"
`default_nettype none
module ptp_top (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             irq_o,
  output logic             output_point_zero_o,
  output logic             output_point_one_o
);
  ptp_pkg::ptp_top_type st_r, st_nxt;
  ptp_gen_if gif ();

  logic        fire;
  logic        wr;
  logic [15:0] wd;
  logic        wneg;
  logic [16:0] wmag;
  logic        sgn_chg;
  logic        f_ok;
  logic        d_ok;
  logic        pwm_m;
  logic        cw_m;
  logic        dir_m;
  logic [16:0] amag;
  logic [6:0]  de;
  logic [31:0] num1;
  logic [31:0] num2;
  logic [31:0] q1;
  logic [31:0] q2;
  logic        d1_done;
  logic        d2_done;
  logic [23:0] hq;
  logic [23:0] lq;
  logic        pw_bad;
  logic [15:0] rd_v;

  // Bus handshake: a request is answered one cycle after it is seen
  assign fire = (avs_read_i || avs_write_i) && !st_r.wt;
  assign wr   = fire && avs_write_i && (avs_byteenable_i[1:0] == 2'h3);
  assign wd   = avs_writedata_i[15:0];

  // Function select decode
  assign pwm_m = (st_r.func == `PTP_FN_PWM);
  assign cw_m  = (st_r.func == `PTP_FN_CWCCW);
  assign dir_m = (st_r.func == `PTP_FN_PLSDIR);

  // Frequency write check; PWM takes positive settings only
  assign wneg    = wd[15];
  assign wmag    = wneg ? (17'h00000 - {wd[15], wd}) : {1'b0, wd};
  assign sgn_chg = st_r.en && st_r.have_f && (wneg != st_r.freq[15]);
  assign f_ok    = (wmag >= `PTP_F_MIN) && (wmag <= `PTP_F_MAX) && !sgn_chg
                   && !(pwm_m && wneg);
  assign d_ok    = (wd <= `PTP_D_MAX);

  // Period = round(clk / f); high = round(period * duty / 100), with duty taken as 50 outside PWM
  assign amag = st_r.freq[15] ? (17'h00000 - {st_r.freq[15], st_r.freq})
                              : {1'b0, st_r.freq};
  assign de   = pwm_m ? st_r.duty : `PTP_D_HALF;
  assign num1 = `PTP_CLK_HZ + 32'(amag >> 1);
  assign num2 = 32'(q1[23:0]) * 32'(de) + `PTP_RND_PCT;
  assign hq   = q2[23:0];
  assign lq   = q1[23:0] - hq;

  // Phases shorter than the minimum only matter when duty is not 0 or 100
  assign pw_bad = pwm_m && (st_r.duty != `PTP_D_ZERO) && (st_r.duty != `PTP_D_FULL)
                  && ((32'(hq) < `PTP_MIN_PH_CYC) || (32'(lq) < `PTP_MIN_PH_CYC));

  ptp_div u_div_per (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .start_i (st_r.sp),
    .num_i   (num1),
    .den_i   (amag[15:0]),
    .done_o  (d1_done),
    .quo_o   (q1)
  );

  ptp_div u_div_high (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .start_i (st_r.sh),
    .num_i   (num2),
    .den_i   (`PTP_D_MAX),
    .done_o  (d2_done),
    .quo_o   (q2)
  );

  ptp_gen u_gen (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .g       (gif.gen)
  );

  assign gif.period = st_r.per;
  assign gif.high   = st_r.high;
  assign gif.run    = st_r.run;

  // Read data mux; unmapped offsets read as zero
  always_comb begin
    case (avs_address_i)
      `PTP_A_FUNC:  rd_v = st_r.func;
      `PTP_A_CTRL:  rd_v = {15'h0000, st_r.en};
      `PTP_A_FREQ:  rd_v = st_r.freq;
      `PTP_A_DUTY:  rd_v = {9'h000, st_r.duty};
      `PTP_A_ERR:   rd_v = {13'h0000, st_r.ferr, st_r.derr, st_r.pwerr};
      `PTP_A_IST:   rd_v = {13'h0000, st_r.ist};
      `PTP_A_IMASK: rd_v = {13'h0000, st_r.imask};
      default:      rd_v = 16'h0000;
    endcase
  end

  // Next state of the whole block
  always_comb begin
    logic [2:0] ev;
    logic [2:0] clr;
    ev  = 3'h0;
    clr = 3'h0;
    st_nxt = st_r;
    st_nxt.sp = 1'b0;
    st_nxt.sh = 1'b0;

    // Bus slave: read data is latched on the waiting cycle
    if (avs_read_i || avs_write_i) begin
      if (st_r.wt) begin
        st_nxt.wt    = 1'b0;
        st_nxt.rdata = rd_v;
      end else begin
        st_nxt.wt = 1'b1;
      end
    end

    // Register writes; a rejected setting leaves the old value in force
    if (wr) begin
      case (avs_address_i)
        `PTP_A_FUNC: begin
          st_nxt.func = wd;
          st_nxt.pend = 1'b1;
        end
        `PTP_A_CTRL: st_nxt.en = wd[`PTP_B_EN];
        `PTP_A_FREQ: begin
          if (f_ok) begin
            st_nxt.freq   = wd;
            st_nxt.have_f = 1'b1;
            st_nxt.ferr   = 1'b0;
            st_nxt.pend   = 1'b1;
          end else begin
            st_nxt.ferr = 1'b1;
            ev[`PTP_B_FREQ] = 1'b1;
          end
        end
        `PTP_A_DUTY: begin
          if (d_ok) begin
            st_nxt.duty = wd[6:0];
            st_nxt.derr = 1'b0;
            st_nxt.pend = 1'b1;
          end else begin
            st_nxt.derr = 1'b1;
            ev[`PTP_B_DUTY] = 1'b1;
          end
        end
        `PTP_A_IST:   clr = wd[2:0];
        `PTP_A_IMASK: st_nxt.imask = wd[2:0];
        default: ;
      endcase
    end

    // Recompute period then high time whenever a setting changes
    unique case (st_r.st)
      ptp_pkg::PTP_IDLE: begin
        if (st_r.pend && st_r.have_f) begin
          st_nxt.pend = 1'b0;
          st_nxt.sp   = 1'b1;
          st_nxt.st   = ptp_pkg::PTP_PER;
        end
      end
      ptp_pkg::PTP_PER: begin
        if (d1_done) begin
          st_nxt.sh = 1'b1;
          st_nxt.st = ptp_pkg::PTP_HIGH;
        end
      end
      ptp_pkg::PTP_HIGH: begin
        if (d2_done) begin
          st_nxt.per   = q1[23:0];
          st_nxt.high  = hq;
          st_nxt.pwerr = pw_bad;
          ev[`PTP_B_PW] = pw_bad;
          st_nxt.st    = ptp_pkg::PTP_IDLE;
        end
      end
    endcase

    // Sticky event bits; a new event beats a clear in the same cycle
    st_nxt.ist = (st_r.ist & ~clr) | ev;
    st_nxt.irq = |(st_nxt.ist & st_nxt.imask);

    // Generation needs enable, a computed period and a known function
    st_nxt.run = st_r.en && (st_r.per != 24'h000000) && (pwm_m || cw_m || dir_m);

    // Output steering; everything low when not running
    st_nxt.p0 = 1'b0;
    st_nxt.p1 = 1'b0;
    if (st_nxt.run) begin
      if (cw_m) begin
        st_nxt.p0 = gif.wave && !st_r.freq[15];
        st_nxt.p1 = gif.wave && st_r.freq[15];
      end else if (dir_m) begin
        st_nxt.p0 = gif.wave;
        st_nxt.p1 = st_r.freq[15];
      end else begin
        st_nxt.p0 = gif.wave;
      end
    end else begin
      st_nxt.p1 = 1'b0;
    end
  end

  // State register; waitrequest rests high between transfers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r    <= '0;
      st_r.wt <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign avs_readdata_o      = {16'h0000, st_r.rdata};
  assign avs_waitrequest_o   = st_r.wt;
  assign irq_o               = st_r.irq;
  assign output_point_zero_o = st_r.p0;
  assign output_point_one_o  = st_r.p1;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_req_seen;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_ack;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  property p_bus_ack;
    s_req_seen |=> s_ack;
  endproperty
  a_bus_ack: assert property (p_bus_ack)
    else $error("bus answer not given one cycle after request");

  property p_off_quiet;
    !st_r.en |=> !output_point_zero_o && !output_point_one_o;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("output active while disabled");

  property p_dir_level;
    st_r.en && st_r.run && dir_m |=> output_point_one_o == $past(st_r.freq[15]);
  endproperty
  a_dir_level: assert property (p_dir_level)
    else $error("direction output does not follow sign");

  property p_cw_side;
    cw_m && !st_r.freq[15] |=> !output_point_one_o;
  endproperty
  a_cw_side: assert property (p_cw_side)
    else $error("pulse on wrong output for positive setting");

  property p_fbad;
    wr && (avs_address_i == `PTP_A_FREQ) && !f_ok |=> st_r.ferr && $stable(st_r.freq);
  endproperty
  a_fbad: assert property (p_fbad)
    else $error("bad frequency accepted or error not raised");

  property p_fgood;
    wr && (avs_address_i == `PTP_A_FREQ) && f_ok |=> !st_r.ferr && st_r.have_f;
  endproperty
  a_fgood: assert property (p_fgood)
    else $error("frequency error not cleared by good setting");

  property p_dbad;
    wr && (avs_address_i == `PTP_A_DUTY) && !d_ok |=> st_r.derr && $stable(st_r.duty);
  endproperty
  a_dbad: assert property (p_dbad)
    else $error("bad duty accepted or error not raised");

  property p_pw;
    (st_r.st == ptp_pkg::PTP_HIGH) && d2_done && pw_bad |=> st_r.pwerr && st_r.ist[`PTP_B_PW];
  endproperty
  a_pw: assert property (p_pw)
    else $error("pulse width error not raised");

  // The divider took its operands 33 edges before done; a later write must not matter
  property p_round;
    (st_r.st == ptp_pkg::PTP_PER) && d1_done |->
      (64'(q1) * 64'($past(amag, 33)) + 64'($past(amag, 33)) >= 64'($past(num1, 33)))
      && (64'(q1) * 64'($past(amag, 33)) <= 64'($past(num1, 33)));
  endproperty
  a_round: assert property (p_round)
    else $error("period count not the rounded division");

  // A write landing in a running recompute waits for it and one more: about 138 cycles
  property p_apply;
    wr && (avs_address_i == `PTP_A_DUTY) && d_ok && st_r.have_f |->
      ##[1:140] ((st_r.st == ptp_pkg::PTP_IDLE) && !st_r.pend);
  endproperty
  a_apply: assert property (p_apply)
    else $error("new duty not applied in time");
endmodule // ptp_top
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the pulse train and PWM output block
`include "ptp_defs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i;
  logic        rst_n_i;
  logic [4:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0]  avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        irq_o;
  logic        output_point_zero_o;
  logic        output_point_one_o;
  logic [15:0] zero_rises;
  logic [15:0] one_rises;
  logic [15:0] zero_falls;
  logic [23:0] zero_high;
  logic [31:0] rd;
  int          failures;
  int          n_tests;

  ptp_top i_ptp_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o),
    .output_point_zero_o(output_point_zero_o), .output_point_one_o(output_point_one_o));
  ptp_load_model i_ptp_load_model (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .point_zero_i(output_point_zero_o), .point_one_i(output_point_one_o),
    .zero_rises_o(zero_rises), .one_rises_o(one_rises), .zero_falls_o(zero_falls),
    .zero_high_o(zero_high));

  // 250 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  // One Avalon transfer; the request stands until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= {16'h0000, d};
    avs_write_i     <= wr;
    avs_read_i      <= ~wr;
    // Read right after the edge, so the values seen are those the edge sampled
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (avs_waitrequest_o !== 1'b0) chk(32'h00000001, 32'h00000000, "bus timeout");
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask

  function automatic logic [15:0] cnt(input int sel);
    return (sel == 0) ? zero_falls : (sel == 1) ? zero_rises : one_rises;
  endfunction

  // Bounded wait for a pulse count of the load to reach its goal
  task automatic wait_cnt(input int sel, input logic [15:0] goal, input int lim);
    int n;
    n = 0;
    while (cnt(sel) !== goal && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    chk({16'h0000, cnt(sel)}, {16'h0000, goal}, "pulse count");
  endtask

  task automatic pause(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic t_reset;
    chk({30'h0, output_point_one_o, output_point_zero_o}, 32'h0, "outputs at rest");
    chk({31'h0, irq_o}, 32'h0, "irq at rest");
    bus(1'b0, `PTP_A_ERR, 16'h0000);
    chk(rd, 32'h0, "error flags");
    bus(1'b1, 5'h1C, 16'hFFFF);
    bus(1'b0, 5'h1C, 16'h0000);
    chk(rd, 32'h0, "unmapped read");
    $display("test reset done");
  endtask

  task automatic t_cw;
    logic [15:0] base;
    logic [15:0] other;
    int          per;
    per = (`PTP_CLK_HZ + 2500) / 5000;
    bus(1'b1, `PTP_A_FREQ, 16'h1388);
    bus(1'b1, `PTP_A_FUNC, `PTP_FN_CWCCW);
    pause(100);
    chk({31'h0, output_point_zero_o}, 32'h0, "pulse before enable");
    base  = zero_falls;
    other = one_rises;
    bus(1'b1, `PTP_A_CTRL, 16'h0001);
    wait_cnt(0, base + 16'h0002, 2 * per + 200);
    chk({8'h00, zero_high}, (per + 1) / 2, "high time");
    chk({16'h0, one_rises}, {16'h0, other}, "counter side quiet");
    bus(1'b1, `PTP_A_FREQ, 16'h0028);
    bus(1'b0, `PTP_A_ERR, 16'h0000);
    chk(rd, 32'h4, "frequency error");
    bus(1'b1, `PTP_A_CTRL, 16'h0000);
    pause(3);
    chk({30'h0, output_point_one_o, output_point_zero_o}, 32'h0, "stopped");
    $display("test clockwise done");
  endtask

  task automatic t_ccw;
    logic [15:0] base;
    logic [15:0] other;
    bus(1'b1, `PTP_A_FREQ, 16'hEC78);
    bus(1'b1, `PTP_A_IST, 16'h0007);
    pause(100);
    base  = zero_rises;
    other = one_rises;
    bus(1'b1, `PTP_A_CTRL, 16'h0001);
    wait_cnt(2, other + 16'h0001, 300);
    chk({16'h0, zero_rises}, {16'h0, base}, "clockwise side quiet");
    // Sign reversal while running, on purpose
    bus(1'b1, `PTP_A_FREQ, 16'h1388);
    bus(1'b0, `PTP_A_ERR, 16'h0000);
    chk(rd, 32'h4, "sign change error");
    bus(1'b1, `PTP_A_IMASK, 16'h0004);
    pause(2);
    chk({31'h0, irq_o}, 32'h1, "irq raised");
    bus(1'b1, `PTP_A_IST, 16'h0004);
    pause(2);
    chk({31'h0, irq_o}, 32'h0, "irq cleared");
    bus(1'b1, `PTP_A_FREQ, 16'hF060);
    bus(1'b0, `PTP_A_ERR, 16'h0000);
    chk(rd, 32'h0, "error cleared itself");
    bus(1'b1, `PTP_A_CTRL, 16'h0000);
    $display("test counter clockwise done");
  endtask

  task automatic t_step;
    logic [15:0] base;
    bus(1'b1, `PTP_A_FUNC, `PTP_FN_PLSDIR);
    bus(1'b1, `PTP_A_FREQ, 16'hEC78);
    pause(100);
    base = zero_rises;
    bus(1'b1, `PTP_A_CTRL, 16'h0001);
    wait_cnt(1, base + 16'h0001, 300);
    chk({31'h0, output_point_one_o}, 32'h1, "direction negative");
    bus(1'b1, `PTP_A_CTRL, 16'h0000);
    pause(3);
    chk({31'h0, output_point_one_o}, 32'h0, "direction released");
    bus(1'b1, `PTP_A_FREQ, 16'h1388);
    pause(100);
    bus(1'b1, `PTP_A_CTRL, 16'h0001);
    pause(100);
    chk({30'h0, output_point_one_o, output_point_zero_o}, 32'h1, "direction positive");
    bus(1'b1, `PTP_A_CTRL, 16'h0000);
    $display("test step direction done");
  endtask

  task automatic t_pwm;
    bus(1'b1, `PTP_A_FUNC, `PTP_FN_PWM);
    bus(1'b1, `PTP_A_DUTY, 16'h0064);
    bus(1'b1, `PTP_A_IMASK, 16'h0000);
    bus(1'b1, `PTP_A_IST, 16'h0007);
    pause(100);
    bus(1'b1, `PTP_A_CTRL, 16'h0001);
    pause(100);
    chk({30'h0, output_point_one_o, output_point_zero_o}, 32'h1, "full duty");
    bus(1'b1, `PTP_A_DUTY, 16'h0000);
    pause(100);
    chk({31'h0, output_point_zero_o}, 32'h0, "zero duty");
    bus(1'b1, `PTP_A_DUTY, 16'h001E);
    pause(100);
    bus(1'b0, `PTP_A_ERR, 16'h0000);
    chk(rd, 32'h1, "phase too short");
    bus(1'b1, `PTP_A_DUTY, 16'h0065);
    bus(1'b0, `PTP_A_ERR, 16'h0000);
    chk(rd, 32'h3, "duty error");
    chk({31'h0, irq_o}, 32'h0, "irq masked");
    bus(1'b1, `PTP_A_IMASK, 16'h0002);
    pause(2);
    chk({31'h0, irq_o}, 32'h1, "irq unmasked");
    bus(1'b1, `PTP_A_DUTY, 16'h0032);
    pause(100);
    bus(1'b0, `PTP_A_ERR, 16'h0000);
    chk(rd, 32'h0, "half duty accepted");
    bus(1'b1, `PTP_A_CTRL, 16'h0000);
    bus(1'b1, `PTP_A_FREQ, 16'h0028);
    bus(1'b0, `PTP_A_ERR, 16'h0000);
    chk(rd, 32'h4, "bad frequency");
    $display("test pwm done");
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Tests take about 80000 cycles; the longest is two full pulses at 5000 Hz
  initial begin
    repeat (100000) @(posedge clk_i);
    failures++;
    $display("FAIL at %0t: watchdog expired", $time);
    end_of_test();
  end

  // Main sequence
  initial begin
    failures         = 0;
    n_tests          = 0;
    rst_n_i          = 1'b0;
    avs_address_i    = 5'h00;
    avs_read_i       = 1'b0;
    avs_write_i      = 1'b0;
    avs_writedata_i  = 32'h00000000;
    avs_byteenable_i = 4'hF;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_cw();
    t_ccw();
    t_step();
    t_pwm();
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
